// File: logic/wdt_cfg.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_ADDR_W          8
`define WDT_DATA_W          32
`define WDT_OFS_CNT         8'hD8
`define WDT_OFS_STAT        8'hDC
`define WDT_CNT_RST         8'hFE
`define WDT_BIT_ARM         0
`define WDT_BIT_GUARD       1
`define WDT_DLY_LSB_POS     7
`define WDT_STAT_ARMED      0
`define WDT_STAT_HW_OPT     1
`define WDT_STAT_EXT_OPT    2
`define WDT_STAT_WAIT       3
`define WDT_STAT_STOP       4
`define WDT_STAT_FIRED      5
`define WDT_CLK_MHZ         25
`define WDT_STEP_CYC        3072
`define WDT_PRE_W           12
`define WDT_PULSE_NS        500
`define WDT_PULSE_CYC       ((`WDT_PULSE_NS * `WDT_CLK_MHZ + 999) / 1000)
`define WDT_PULSE_W         4

`endif

// File: logic/wdt_pkg.sv
// Types shared by the watchdog block
package wdt_pkg;
	typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} wdt_pmode_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} wdt_avs_req_t;

	typedef struct packed {
		logic wait_req;
		logic stop_req;
		logic wake_irq;
	} wdt_cpu_evt_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic        tick;
	} wdt_pre_st_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       out_n;
	} wdt_pls_st_t;

	typedef struct packed {
		logic [6:0]  cnt;
		logic        sw_arm;
		logic        hw_opt;
		logic        ext_opt;
		logic        fired;
		wdt_pmode_t  mode;
		logic        wait_o;
		logic        stop_o;
		logic        waitreq;
		logic [31:0] rdata;
	} wdt_top_st_t;
endpackage

// File: logic/wdt_prescale.sv
// Step divider: one-cycle tick every 3072 clocks, restartable and freezable
`include "wdt_cfg.svh"
module wdt_prescale (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic restart,
	input  wire logic run,
	output logic      tick
);
	import wdt_pkg::*;

	localparam logic [11:0] LAST = 12'(`WDT_STEP_CYC - 1);

	wdt_pre_st_t st_r;
	wdt_pre_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (restart) begin
			st_nxt.cnt = 12'h000;
		end else if (run) begin
			if (st_r.cnt == LAST) begin
				st_nxt.cnt = 12'h000;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 12'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule

// File: logic/wdt_rst_pulse.sv
// Low-going reset pulse of fixed length
`include "wdt_cfg.svh"
module wdt_rst_pulse (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      rst_n
);
	import wdt_pkg::*;

	localparam logic [3:0] LEN_M1 = 4'(`WDT_PULSE_CYC - 1);

	wdt_pls_st_t st_r;
	wdt_pls_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!st_r.out_n) begin
			if (st_r.cnt == 4'h0) begin
				st_nxt.out_n = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 4'h1;
			end
		end else if (start) begin
			st_nxt.out_n = 1'b0;
			st_nxt.cnt = LEN_M1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '{cnt: 4'h0, out_n: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rst_n = st_r.out_n;
endmodule

// File: logic/wdt_top.sv
// Watchdog downcounter with software reset, Avalon-MM register slave
`include "wdt_cfg.svh"

// How it works
// - Hardware option: armed from reset, arm bit forced high, writes ignored.
// - Software option: idle after reset; arm bit set once, stays until reset.
// - Seven-bit counter (guard plus delay bits) decrements every 3072 clocks.
// - Timeout set in 64 steps, each one decrement interval.
// - Armed and guard bit zero starts a short low pulse on the reset output.
// - At 8 MHz, FEh gives 24.576 ms and 02h gives 0.384 ms.
// - Writing guard bit clear while armed resets the device at once.
// - Unarmed under software option, counter keeps running as reversed 7-bit timer.
// - WAIT leaves the watchdog counting, untouched.
// - Watchdog inactive: STOP enters STOP normally.
// - Active watchdog without external stop gate: STOP behaves as WAIT.
// - Active with gate: NMI low gives WAIT; NMI high freezes counter, enters STOP.
// - Leaving STOP by interrupt resumes counting from the held value.
// - Register bits 7..2 delay count, bit 7 its LSB; bit 1 guard; bit 0 arm.
// - Counter register resets to FEh.
module wdt_top (
	input  wire logic          SYS_CLK,
	input  wire logic          RST,
	input  wire wdt_pkg::wdt_avs_req_t AVS_REQ,
	output logic [31:0]        AVS_READDATA,
	output logic               AVS_WAITREQUEST,
	input  wire wdt_pkg::wdt_cpu_evt_t CPU_EVT,
	input  wire logic          NMI_PIN,
	input  wire logic          ACTIVATION_OPTION,
	input  wire logic          EXTERNAL_STOP_GATE_OPTION,
	output logic               WDG_RST_N,
	output logic               WAIT_MODE,
	output logic               STOP_MODE
);
	import wdt_pkg::*;

	// Register byte to physical counter: delay bits are stored reversed
	function automatic logic [6:0] reg_to_cnt(input logic [7:0] b);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 0; i < 6; i++) begin
			c[i] = b[`WDT_DLY_LSB_POS - i];
		end
		c[6] = b[`WDT_BIT_GUARD];
		return c;
	endfunction

	// Physical counter back to register layout
	function automatic logic [7:0] cnt_to_reg(input logic [6:0] c, input logic arm);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 6; i++) begin
			b[`WDT_DLY_LSB_POS - i] = c[i];
		end
		b[`WDT_BIT_GUARD] = c[6];
		b[`WDT_BIT_ARM] = arm;
		return b;
	endfunction

	localparam logic [7:0] CNT_RST_VAL = `WDT_CNT_RST;

	wdt_top_st_t st_r;
	wdt_top_st_t st_nxt;

	logic       tick;
	logic       armed;
	logic       req;
	logic       done;
	logic       cnt_wr;
	logic       start_rst;
	logic       cnt_run;
	logic [7:0] wbyte;

	// Options are straps caught while reset is held
	assign armed = st_r.hw_opt | st_r.sw_arm;
	assign req = AVS_REQ.read | AVS_REQ.write;
	assign done = req & ~st_r.waitreq;
	assign wbyte = AVS_REQ.writedata[7:0];
	assign cnt_wr = done & AVS_REQ.write & (AVS_REQ.address == `WDT_OFS_CNT) & AVS_REQ.byteenable[0];
	// Counter frozen only in true STOP
	assign cnt_run = (st_r.mode != PM_STOP);
	// Fired flag keeps one event from pulsing again until device reset
	assign start_rst = armed & ~st_r.cnt[6] & ~st_r.fired;

	wdt_prescale u_pre (
		.clk     (SYS_CLK),
		.rst     (RST),
		.restart (cnt_wr),
		.run     (cnt_run),
		.tick    (tick)
	);

	wdt_rst_pulse u_pls (
		.clk   (SYS_CLK),
		.rst   (RST),
		.start (start_rst),
		.rst_n (WDG_RST_N)
	);

	always_comb begin
		st_nxt = st_r;

		// Counter: write beats a coinciding decrement
		if (cnt_wr) begin
			st_nxt.cnt = reg_to_cnt(wbyte);
		end else if (tick) begin
			st_nxt.cnt = st_r.cnt - 7'h01;
		end

		// Arm bit only sets; clearing writes have no effect
		if (cnt_wr && wbyte[`WDT_BIT_ARM]) begin
			st_nxt.sw_arm = 1'b1;
		end

		// Guard cleared by write with arm set trips next cycle
		if (start_rst) begin
			st_nxt.fired = 1'b1;
		end

		// Power mode sequencing
		case (st_r.mode)
			PM_RUN: begin
				if (CPU_EVT.stop_req) begin
					if (!armed) begin
						st_nxt.mode = PM_STOP;
					end else if (!st_r.ext_opt) begin
						st_nxt.mode = PM_WAIT;
					end else if (NMI_PIN) begin
						st_nxt.mode = PM_STOP;
					end else begin
						st_nxt.mode = PM_WAIT;
					end
				end else if (CPU_EVT.wait_req) begin
					st_nxt.mode = PM_WAIT;
				end
			end
			PM_WAIT: begin
				if (CPU_EVT.wake_irq) begin
					st_nxt.mode = PM_RUN;
				end
			end
			PM_STOP: begin
				if (CPU_EVT.wake_irq) begin
					st_nxt.mode = PM_RUN;
				end
			end
			default: begin
				st_nxt.mode = PM_RUN;
			end
		endcase
		st_nxt.wait_o = (st_nxt.mode == PM_WAIT);
		st_nxt.stop_o = (st_nxt.mode == PM_STOP);

		// Bus: one wait cycle, read data captured then held while answered
		if (done) begin
			st_nxt.waitreq = 1'b1;
		end else if (req) begin
			st_nxt.waitreq = 1'b0;
			st_nxt.rdata = 32'h0000_0000;
			if (AVS_REQ.read) begin
				case (AVS_REQ.address)
					`WDT_OFS_CNT: begin
						// Counter may be mid-decrement; software reads twice
						st_nxt.rdata[7:0] = cnt_to_reg(st_r.cnt, armed);
					end
					`WDT_OFS_STAT: begin
						st_nxt.rdata[`WDT_STAT_ARMED] = armed;
						st_nxt.rdata[`WDT_STAT_HW_OPT] = st_r.hw_opt;
						st_nxt.rdata[`WDT_STAT_EXT_OPT] = st_r.ext_opt;
						st_nxt.rdata[`WDT_STAT_WAIT] = st_r.wait_o;
						st_nxt.rdata[`WDT_STAT_STOP] = st_r.stop_o;
						st_nxt.rdata[`WDT_STAT_FIRED] = st_r.fired;
					end
					default: begin
						st_nxt.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_r.cnt <= reg_to_cnt(CNT_RST_VAL);
			st_r.sw_arm <= 1'b0;
			st_r.hw_opt <= ACTIVATION_OPTION;
			st_r.ext_opt <= EXTERNAL_STOP_GATE_OPTION;
			st_r.fired <= 1'b0;
			st_r.mode <= PM_RUN;
			st_r.wait_o <= 1'b0;
			st_r.stop_o <= 1'b0;
			st_r.waitreq <= 1'b1;
			st_r.rdata <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign AVS_READDATA = st_r.rdata;
	assign AVS_WAITREQUEST = st_r.waitreq;
	assign WAIT_MODE = st_r.wait_o;
	assign STOP_MODE = st_r.stop_o;
endmodule

// File: bench/wdt_top_props.sv
// Port assertions for the watchdog top
module wdt_top_props
	import wdt_pkg::*;
(
	input wire logic                  SYS_CLK,
	input wire logic                  RST,
	input wire wdt_pkg::wdt_avs_req_t AVS_REQ,
	input wire logic                  AVS_WAITREQUEST,
	input wire wdt_pkg::wdt_cpu_evt_t CPU_EVT,
	input wire logic                  NMI_PIN,
	input wire logic                  ACTIVATION_OPTION,
	input wire logic                  EXTERNAL_STOP_GATE_OPTION,
	input wire logic                  WDG_RST_N,
	input wire logic                  WAIT_MODE,
	input wire logic                  STOP_MODE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	// Pulse fires once per reset, so later guard writes are exempt
	logic shot_r;
	wire  run = !WAIT_MODE && !STOP_MODE;
	wire  stp = CPU_EVT.stop_req && run && ACTIVATION_OPTION;
	wire  wr_done = AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.address == 8'hD8 && AVS_REQ.byteenable[0];
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			shot_r <= 1'b0;
		else if (!WDG_RST_N)
			shot_r <= 1'b1;
	end
	chk_pulse_len: assert property ($fell(WDG_RST_N) |-> !WDG_RST_N[*8] ##1 !WDG_RST_N[*5] ##1 WDG_RST_N)
		else $error("reset pulse length wrong");
	chk_soft_reset: assert property (wr_done && AVS_REQ.writedata[1:0] == 2'h1 && ACTIVATION_OPTION && !shot_r
		|-> ##[1:3] !WDG_RST_N) else $error("guard clear did not reset");
	chk_stop_gated: assert property (stp && EXTERNAL_STOP_GATE_OPTION && NMI_PIN |=> STOP_MODE && !WAIT_MODE)
		else $error("gated stop not entered");
	chk_nmi_low: assert property (stp && EXTERNAL_STOP_GATE_OPTION && !NMI_PIN |=> WAIT_MODE && !STOP_MODE)
		else $error("stop with nmi low not wait");
	chk_stop_as_wait: assert property (stp && !EXTERNAL_STOP_GATE_OPTION |=> WAIT_MODE && !STOP_MODE)
		else $error("stop not taken as wait");
	chk_wait_entry: assert property (CPU_EVT.wait_req && run |=> WAIT_MODE)
		else $error("wait not entered");
	chk_wake_run: assert property (CPU_EVT.wake_irq |=> run)
		else $error("wake did not return to run");
	chk_stop_frozen: assert property (STOP_MODE |-> !$fell(WDG_RST_N))
		else $error("pulse started in stop");
endmodule

// File: bench/wdt_top_tb_top.sv
// Self-checking bench for the watchdog top
module wdt_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import wdt_pkg::*;
	logic         SYS_CLK = 1'b0;
	logic         RST = 1'b1;
	wdt_avs_req_t AVS_REQ = '0;
	wdt_cpu_evt_t CPU_EVT = '0;
	logic         NMI_PIN = 1'b0;
	logic         ACTIVATION_OPTION = 1'b1;
	logic         EXTERNAL_STOP_GATE_OPTION = 1'b1;
	logic [31:0]  AVS_READDATA;
	logic         AVS_WAITREQUEST;
	logic         WDG_RST_N;
	logic         WAIT_MODE;
	logic         STOP_MODE;
	logic [31:0]  rd;
	int           errors = 0;
	int           n_tests = 0;
	wdt_top wdt_top_inst (.SYS_CLK, .RST, .AVS_REQ, .AVS_READDATA, .AVS_WAITREQUEST, .CPU_EVT, .NMI_PIN,
		.ACTIVATION_OPTION, .EXTERNAL_STOP_GATE_OPTION, .WDG_RST_N, .WAIT_MODE, .STOP_MODE);
	always #20 SYS_CLK = ~SYS_CLK;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Straps are captured only while reset is high
	task automatic boot(input logic act, input logic ext);
		@(posedge SYS_CLK);
		RST <= 1'b1;
		ACTIVATION_OPTION <= act;
		EXTERNAL_STOP_GATE_OPTION <= ext;
		repeat (4) @(posedge SYS_CLK);
		RST <= 1'b0;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge SYS_CLK);
		AVS_REQ <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
		k = 0;
		do begin
			@(posedge SYS_CLK);
			k++;
		end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
		if (k == 50)
			errors++;
		rd = AVS_READDATA;
		AVS_REQ <= '0;
	endtask
	task automatic wait_low(input int lim, input logic lv);
		int k;
		k = 0;
		while (WDG_RST_N !== 1'b0 && k < lim) begin
			@(posedge SYS_CLK);
			k++;
		end
		check(32'(WDG_RST_N), 32'(lv));
	endtask
	task automatic evt(input wdt_cpu_evt_t e, input logic [31:0] exp);
		@(posedge SYS_CLK);
		CPU_EVT <= e;
		@(posedge SYS_CLK);
		CPU_EVT <= '0;
		@(posedge SYS_CLK);
		check(32'({STOP_MODE, WAIT_MODE}), exp);
	endtask
	initial begin
		boot(1'b1, 1'b1);
		bus(1'b0, 8'hD8, 8'h00);
		check(rd, 32'hFF);
		bus(1'b0, 8'h40, 8'h00);
		check(rd, 32'h0);
		bus(1'b1, 8'hD8, 8'h83);
		bus(1'b0, 8'hD8, 8'h00);
		check(rd, 32'h83);
		bus(1'b1, 8'hD8, 8'h03);
		wait_low(3060, 1'b1);
		wait_low(30, 1'b0);
		repeat (20) @(posedge SYS_CLK);
		boot(1'b1, 1'b0);
		evt(3'h2, 32'h1);
		evt(3'h1, 32'h0);
		bus(1'b1, 8'hD8, 8'h01);
		wait_low(4, 1'b0);
		bus(1'b0, 8'hDC, 8'h00);
		check(rd, 32'h23);
		repeat (20) @(posedge SYS_CLK);
		boot(1'b1, 1'b1);
		bus(1'b1, 8'hD8, 8'h03);
		NMI_PIN <= 1'b1;
		evt(3'h2, 32'h2);
		wait_low(4000, 1'b1);
		evt(3'h1, 32'h0);
		wait_low(3100, 1'b0);
		repeat (20) @(posedge SYS_CLK);
		NMI_PIN <= 1'b0;
		boot(1'b1, 1'b1);
		evt(3'h2, 32'h1);
		evt(3'h1, 32'h0);
		bus(1'b1, 8'hD8, 8'h03);
		evt(3'h4, 32'h1);
		wait_low(3100, 1'b0);
		boot(1'b0, 1'b0);
		bus(1'b0, 8'hD8, 8'h00);
		check(rd, 32'hFE);
		evt(3'h2, 32'h2);
		evt(3'h1, 32'h0);
		bus(1'b1, 8'hD8, 8'h02);
		wait_low(3100, 1'b1);
		bus(1'b0, 8'hD8, 8'h00);
		check(rd, 32'hFC);
		bus(1'b0, 8'hD8, 8'h00);
		check(rd, 32'hFC);
		bus(1'b1, 8'hD8, 8'hFF);
		bus(1'b1, 8'hD8, 8'hFE);
		bus(1'b0, 8'hD8, 8'h00);
		check(rd, 32'hFF);
		end_of_test();
	end
	// Whole run is near 16500 cycles
	initial begin
		repeat (60000) @(posedge SYS_CLK);
		errors++;
		end_of_test();
	end
endmodule

bind wdt_top wdt_top_props wdt_top_props_inst (.SYS_CLK, .RST, .AVS_REQ, .AVS_WAITREQUEST, .CPU_EVT, .NMI_PIN,
	.ACTIVATION_OPTION, .EXTERNAL_STOP_GATE_OPTION, .WDG_RST_N, .WAIT_MODE, .STOP_MODE);
